/* File: sfcp_pkg.sv */
// Shared constants, enumerations and state carrier for the serial flash
// command front end. Assumes the user compiles it before every module.
package sfcp_pkg;

  // Opcodes
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD_CMD  = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE_CMD_CMD  = 8'h04;
  localparam logic [7:0] OPC_RD_STAT   = 8'h05;
  localparam logic [7:0] OPC_WR_STAT   = 8'h01;
  localparam logic [7:0] OPC_READ      = 8'h03;
  localparam logic [7:0] OPC_FAST      = 8'h0B;
  localparam logic [7:0] OPC_DUAL      = 8'h3B;
  localparam logic [7:0] OPC_PAGE      = 8'h02;
  localparam logic [7:0] OPC_SECTOR    = 8'h20;
  localparam logic [7:0] OPC_BLK32     = 8'h52;
  localparam logic [7:0] OPC_BLK64     = 8'hD8;
  localparam logic [7:0] OPC_CHIP_A    = 8'h60;
  localparam logic [7:0] OPC_CHIP_B    = 8'hC7;
  localparam logic [7:0] OPC_IDENT     = 8'h90;
  localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
  localparam logic [7:0] OPC_SEC_PROG  = 8'h42;
  localparam logic [7:0] OPC_SEC_READ  = 8'h48;
  localparam logic [7:0] OPC_SLEEP     = 8'hB9;
  localparam logic [7:0] OPC_WAKE      = 8'hAB;

  // Status bit positions
  localparam int S_BUSY = 0;
  localparam int S_WEL  = 1;
  localparam int S_BP0  = 2;
  localparam int S_BP2  = 4;
  localparam int S_CMP  = 5;
  localparam int S_LOCK = 6;
  localparam int S_SRP  = 7;

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] PIN_RESET    = 4'h9;

  // Identity bytes; values are arbitrary
  localparam logic [7:0] MAKER_CODE  = 8'h5A;
  localparam logic [7:0] DEVICE_CODE = 8'hA5;

  // Sizes
  localparam int FIFO_DEPTH = 32;
  localparam int ADDR_BYTES = 3;

  typedef enum logic [2:0] {
    P_OP, P_ADDR, P_DUMMY, P_DIN, P_DOUT, P_IGNORE
  } sfcp_phase_e;

  typedef enum logic [3:0] {
    OP_NONE, OP_STATUS, OP_PAGE, OP_SECTOR, OP_BLK32, OP_BLK64,
    OP_CHIP, OP_SEC_ERASE, OP_SEC_PROG, OP_SLEEP, OP_WAKE
  } sfcp_op_e;

  typedef struct packed {
    sfcp_phase_e phase;
    logic [7:0]  opcode;
    logic        opdone;
    logic [7:0]  shreg;
    logic [2:0]  bitcnt;
    logic [2:0]  bytecnt;
    logic [23:0] addr;
    logic [7:0]  shout;
    logic [2:0]  ocnt;
    logic        idsel;
    logic        sclk_q;
    logic        sel_q;
    logic        status_lock_select;
    logic        lb;
    logic        cmp;
    logic [2:0]  bp;
    logic        write_enable_latch;
    logic        sleep;
    logic        ovf;
    logic        do_out;
    logic        do_oe;
    logic        di_out;
    logic        di_oe;
    logic        op_valid;
    sfcp_op_e    op_kind;
    logic [23:0] op_addr;
    logic [23:0] mem_addr;
    logic        push;
    logic [7:0]  push_data;
    logic        flush;
  } sfcp_state_s;

endpackage : sfcp_pkg

/* File: sfcp_sync.sv */
// Two-stage synchroniser for a group of pin levels.
// Assumes the pins are asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module sfcp_sync #(
  parameter int               WIDTH     = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : sfcp_sync
`default_nettype wire

/* File: sfcp_fifo.sv */
// Program data buffer between link and array core, with flush.
// Assumes DEPTH is a power of two.
`timescale 1ns/10ps
`default_nettype none
module sfcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [DEPTH-1:0][WIDTH-1:0] mem;
  logic [AW:0]                 wr_ptr;
  logic [AW:0]                 rd_ptr;
  logic                        full;
  logic                        empty;

  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (!rst_b || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) begin
        mem[wr_ptr[AW-1:0]] <= in_data;
        wr_ptr              <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule : sfcp_fifo
`default_nettype wire

/* File: sfcp_top.sv */
// Command front end of a serial NOR flash: framing, decode, protection bits.
// Assumes pins are asynchronous and the link clock is far slower than clk.
//
// Notes on behaviour
// RULE1: Lock select 0: status write accepted with latch set, any protect pin level.
// RULE2: Lock select 1 and protect pin low: status writes ignored.
// RULE3: Lock select 1 and protect pin high: status write needs latch set.
// RULE4: Complement protect held as status bit 5, reset 0.
// RULE5: Secure area lock held as status bit 6, reset 0.
// RULE6: Secure area lock never clears; security erase and program then refused.
// RULE7: Bytes arrive MSB first, opcode first, sampled on rising serial clock.
// RULE8: Host sends needed address and data bytes, then raises select.
// RULE9: Read data keeps shifting out until select rises.
// RULE10: Modifying commands run only if select rises on a byte boundary.
// RULE11: Page program with partial last byte programs nothing, keeps latch.
// RULE12: 06H sets the write enable latch, 04H clears it.
// RULE13: 05H returns status, bit 7 first, repeated while selected.
// RULE14: Status write is 01H plus exactly one data byte.
// RULE15: 03H plus three address bytes returns data without dummy byte.
// RULE16: 0BH needs three address bytes and a dummy before data.
// RULE17: Dual read puts odd bits on high line, even bits on low line.
// RULE18: 02H plus address then data bytes feeds program data.
// RULE19: 20H, 52H, D8H are erases with exactly three address bytes.
// RULE20: 60H or C7H is chip erase with no further bytes.
// RULE21: 90H plus three bytes returns maker then device code repeatedly.
// RULE22: 44H, 42H, 48H handle security erase, program and read.
// RULE23: Status write, program or erase only accepted with latch set.
// RULE24: Latch cleared at reset, write disable and accepted modifying commands.
// RULE25: Status write leaves busy and latch bits untouched by data.
// RULE26: Unknown opcode ignored, output stays off until select rises.
// RULE27: Discarded commands leave status, latch and array untouched.
`timescale 1ns/10ps
`default_nettype none
module sfcp_top #(
  parameter int FIFO_W = 8,
  parameter int FIFO_D = sfcp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Link pins
  input  wire logic              select_b,
  input  wire logic              serial_clk,
  input  wire logic              dual_line_low_in,
  output var  logic              dual_line_low_out,
  output var  logic              dual_line_low_oe,
  output var  logic              dual_line_high_out,
  output var  logic              dual_line_high_oe,
  input  wire logic              write_protect_b,
  // Array core commands
  input  wire logic              core_busy,
  output var  logic              op_valid,
  output var  sfcp_pkg::sfcp_op_e op_kind,
  output var  logic [23:0]       op_addr,
  // Array core read path
  output var  logic [23:0]       mem_addr,
  input  wire logic [7:0]        mem_rdata,
  // Program data
  output var  logic              prog_valid,
  input  wire logic              prog_ready,
  output var  logic [FIFO_W-1:0] prog_data,
  // Status view
  output var  logic [7:0]        status_byte
);

  sfcp_pkg::sfcp_state_s st;
  sfcp_pkg::sfcp_state_s next_st;

  logic [3:0] pins;
  logic       pin_sel_b;
  logic       pin_sclk;
  logic       pin_si;
  logic       pin_wp_b;
  logic       fifo_ready;
  logic       exec_ev;
  logic [2:0] wr_bp;

  sfcp_sync #(
    .WIDTH     (4),
    .RESET_VAL (sfcp_pkg::PIN_RESET)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   ({select_b, serial_clk, dual_line_low_in, write_protect_b}),
    .dout  (pins)
  );

  assign {pin_sel_b, pin_sclk, pin_si, pin_wp_b} = pins;

  sfcp_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .flush     (st.flush),
    .in_valid  (st.push),
    .in_ready  (fifo_ready),
    .in_data   (st.push_data),
    .out_valid (prog_valid),
    .out_ready (prog_ready),
    .out_data  (prog_data)
  );

  // Status byte as read back
  function automatic logic [7:0] stat_of(input sfcp_pkg::sfcp_state_s s, input logic busy);
    logic [7:0] b;
    b                                 = sfcp_pkg::STATUS_RESET;
    b[sfcp_pkg::S_SRP]                = s.status_lock_select;
    b[sfcp_pkg::S_LOCK]               = s.lb;
    b[sfcp_pkg::S_CMP]                = s.cmp;
    b[sfcp_pkg::S_BP2:sfcp_pkg::S_BP0] = s.bp;
    b[sfcp_pkg::S_WEL]                = s.write_enable_latch;
    b[sfcp_pkg::S_BUSY]               = busy;
    return b;
  endfunction : stat_of

  // Phase after the opcode byte
  function automatic sfcp_pkg::sfcp_phase_e phase_after_op(input logic [7:0] opc);
    case (opc)
      sfcp_pkg::OPC_READ, sfcp_pkg::OPC_FAST, sfcp_pkg::OPC_DUAL,
      sfcp_pkg::OPC_PAGE, sfcp_pkg::OPC_SECTOR, sfcp_pkg::OPC_BLK32,
      sfcp_pkg::OPC_BLK64, sfcp_pkg::OPC_IDENT, sfcp_pkg::OPC_SEC_ERASE,
      sfcp_pkg::OPC_SEC_PROG, sfcp_pkg::OPC_SEC_READ: phase_after_op = sfcp_pkg::P_ADDR;
      sfcp_pkg::OPC_RD_STAT: phase_after_op = sfcp_pkg::P_DOUT;
      sfcp_pkg::OPC_WRITE_ENABLE_CMD_CMD, sfcp_pkg::OPC_WRITE_DISABLE_CMD_CMD, sfcp_pkg::OPC_WR_STAT,
      sfcp_pkg::OPC_CHIP_A, sfcp_pkg::OPC_CHIP_B, sfcp_pkg::OPC_SLEEP,
      sfcp_pkg::OPC_WAKE: phase_after_op = sfcp_pkg::P_DIN;
      default: phase_after_op = sfcp_pkg::P_IGNORE;
    endcase
  endfunction : phase_after_op

  // Reads carrying a dummy byte
  function automatic logic has_dummy(input logic [7:0] opc);
    return (opc == sfcp_pkg::OPC_FAST) || (opc == sfcp_pkg::OPC_DUAL) ||
           (opc == sfcp_pkg::OPC_SEC_READ);
  endfunction : has_dummy

  // Array reads refused while busy
  function automatic logic is_array_read(input logic [7:0] opc);
    return has_dummy(opc) || (opc == sfcp_pkg::OPC_READ);
  endfunction : is_array_read

  assign exec_ev = pin_sel_b && !st.sel_q && (st.phase != sfcp_pkg::P_IGNORE);
  assign wr_bp   = st.shreg[sfcp_pkg::S_BP2:sfcp_pkg::S_BP0];

  always_comb begin
    logic       aligned;
    logic       wel_ok;
    logic       dual;
    logic [7:0] inb;
    logic [7:0] outb;
    logic       wrap;
    aligned = 1'b0;
    wel_ok  = 1'b0;
    dual    = 1'b0;
    inb     = 8'h00;
    outb    = 8'h00;
    wrap    = 1'b0;
    next_st          = st;
    next_st.op_valid = 1'b0;
    next_st.push     = 1'b0;
    next_st.flush    = 1'b0;
    next_st.sclk_q   = pin_sclk;
    next_st.sel_q    = pin_sel_b;
    // Byte refused by a full buffer spoils the program
    if (st.push && !fifo_ready) next_st.ovf = 1'b1;
    if (pin_sel_b) begin
      if (exec_ev) begin
        aligned = st.opdone && (st.bitcnt == 3'h0); // RULE10
        wel_ok  = aligned && st.write_enable_latch && !core_busy && !st.sleep; // RULE23
        next_st.op_addr = st.addr;
        case (st.opcode)
          sfcp_pkg::OPC_WRITE_ENABLE_CMD_CMD: begin
            if (aligned && !core_busy && !st.sleep) next_st.write_enable_latch = 1'b1; // RULE12
          end
          sfcp_pkg::OPC_WRITE_DISABLE_CMD_CMD: begin
            if (aligned && !core_busy) next_st.write_enable_latch = 1'b0; // RULE24
          end
          sfcp_pkg::OPC_WR_STAT: begin
            // RULE14
            if (wel_ok && st.bytecnt == 3'h1 && (!st.status_lock_select || pin_wp_b)) begin // RULE1 RULE2 RULE3
              next_st.status_lock_select      = st.shreg[sfcp_pkg::S_SRP];
              next_st.lb       = st.lb | st.shreg[sfcp_pkg::S_LOCK]; // RULE6
              next_st.cmp      = st.shreg[sfcp_pkg::S_CMP]; // RULE4
              next_st.bp       = wr_bp; // RULE25
              next_st.write_enable_latch      = 1'b0;
              next_st.op_valid = 1'b1;
              next_st.op_kind  = sfcp_pkg::OP_STATUS;
            end
          end
          sfcp_pkg::OPC_PAGE, sfcp_pkg::OPC_SEC_PROG: begin
            if (wel_ok && st.bytecnt > 3'h3 && !st.ovf &&
                (st.opcode == sfcp_pkg::OPC_PAGE || !st.lb)) begin // RULE6
              next_st.write_enable_latch      = 1'b0;
              next_st.op_valid = 1'b1;
              next_st.op_kind  = (st.opcode == sfcp_pkg::OPC_PAGE) ?
                                 sfcp_pkg::OP_PAGE : sfcp_pkg::OP_SEC_PROG;
            end else begin
              next_st.flush = 1'b1; // RULE11 RULE27
            end
          end
          sfcp_pkg::OPC_SECTOR, sfcp_pkg::OPC_BLK32, sfcp_pkg::OPC_BLK64,
          sfcp_pkg::OPC_SEC_ERASE: begin
            if (wel_ok && st.bytecnt == 3'h3 &&
                (st.opcode != sfcp_pkg::OPC_SEC_ERASE || !st.lb)) begin // RULE19
              next_st.write_enable_latch      = 1'b0;
              next_st.op_valid = 1'b1;
              case (st.opcode)
                sfcp_pkg::OPC_SECTOR: next_st.op_kind = sfcp_pkg::OP_SECTOR;
                sfcp_pkg::OPC_BLK32:  next_st.op_kind = sfcp_pkg::OP_BLK32;
                sfcp_pkg::OPC_BLK64:  next_st.op_kind = sfcp_pkg::OP_BLK64;
                default:              next_st.op_kind = sfcp_pkg::OP_SEC_ERASE;
              endcase
            end
          end
          sfcp_pkg::OPC_CHIP_A, sfcp_pkg::OPC_CHIP_B: begin
            if (wel_ok && st.bytecnt == 3'h0) begin // RULE20
              next_st.write_enable_latch      = 1'b0;
              next_st.op_valid = 1'b1;
              next_st.op_kind  = sfcp_pkg::OP_CHIP;
            end
          end
          sfcp_pkg::OPC_SLEEP: begin
            if (aligned && !core_busy) begin
              next_st.sleep    = 1'b1;
              next_st.op_valid = 1'b1;
              next_st.op_kind  = sfcp_pkg::OP_SLEEP;
            end
          end
          sfcp_pkg::OPC_WAKE: begin
            if (st.opdone) begin
              next_st.sleep    = 1'b0;
              next_st.op_valid = 1'b1;
              next_st.op_kind  = sfcp_pkg::OP_WAKE;
            end
          end
          default: begin
          end
        endcase
      end
      // Deselected: framing back to opcode
      next_st.phase   = sfcp_pkg::P_OP;
      next_st.opdone  = 1'b0;
      next_st.bitcnt  = 3'h0;
      next_st.bytecnt = 3'h0;
      next_st.ocnt    = 3'h0;
      next_st.idsel   = 1'b0;
      next_st.ovf     = 1'b0;
      next_st.do_oe   = 1'b0; // RULE9
      next_st.di_oe   = 1'b0;
    end else if (pin_sclk && !st.sclk_q) begin
      // Rising edge: shift in, MSB first
      inb            = {st.shreg[6:0], pin_si}; // RULE7
      next_st.shreg  = inb;
      next_st.bitcnt = 3'(st.bitcnt + 3'h1);
      if (st.bitcnt == 3'h7) begin
        if (st.bytecnt != 3'h7 && st.phase != sfcp_pkg::P_OP) begin
          next_st.bytecnt = 3'(st.bytecnt + 3'h1);
        end
        case (st.phase)
          sfcp_pkg::P_OP: begin
            next_st.opcode = inb;
            next_st.opdone = 1'b1;
            if ((st.sleep && inb != sfcp_pkg::OPC_WAKE) ||
                (core_busy && is_array_read(inb))) begin
              next_st.phase = sfcp_pkg::P_IGNORE;
            end else begin
              next_st.phase = phase_after_op(inb); // RULE26
            end
          end
          sfcp_pkg::P_ADDR: begin
            next_st.addr = {st.addr[15:0], inb};
            if (st.bytecnt == 3'(sfcp_pkg::ADDR_BYTES - 1)) begin
              next_st.mem_addr = {st.addr[15:0], inb};
              if (has_dummy(st.opcode)) begin
                next_st.phase = sfcp_pkg::P_DUMMY; // RULE16
              end else if (st.opcode == sfcp_pkg::OPC_READ ||
                           st.opcode == sfcp_pkg::OPC_IDENT) begin
                next_st.phase = sfcp_pkg::P_DOUT; // RULE15 RULE21
              end else begin
                next_st.phase = sfcp_pkg::P_DIN;
              end
            end
          end
          sfcp_pkg::P_DUMMY: next_st.phase = sfcp_pkg::P_DOUT;
          sfcp_pkg::P_DIN: begin
            if (st.opcode == sfcp_pkg::OPC_PAGE || st.opcode == sfcp_pkg::OPC_SEC_PROG) begin
              next_st.push      = 1'b1; // RULE18 RULE22
              next_st.push_data = inb;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (!pin_sclk && st.sclk_q && st.phase == sfcp_pkg::P_DOUT) begin
      // Falling edge: shift out
      dual = (st.opcode == sfcp_pkg::OPC_DUAL);
      if (st.ocnt != 3'h0) begin
        outb = st.shout;
      end else if (st.opcode == sfcp_pkg::OPC_RD_STAT) begin
        outb = stat_of(st, core_busy); // RULE13
      end else if (st.opcode == sfcp_pkg::OPC_IDENT) begin
        outb = st.idsel ? sfcp_pkg::DEVICE_CODE : sfcp_pkg::MAKER_CODE;
      end else begin
        outb = mem_rdata;
      end
      next_st.do_out = outb[7];
      next_st.do_oe  = 1'b1;
      if (dual) begin
        next_st.di_out = outb[6]; // RULE17
        next_st.di_oe  = 1'b1;
        next_st.shout  = {outb[5:0], 2'h0};
        wrap           = (st.ocnt == 3'h3);
      end else begin
        next_st.shout = {outb[6:0], 1'h0};
        wrap          = (st.ocnt == 3'h7);
      end
      next_st.ocnt = wrap ? 3'h0 : 3'(st.ocnt + 3'h1);
      if (wrap) begin
        next_st.idsel    = !st.idsel;
        next_st.addr     = 24'(st.addr + 24'h00_0001);
        next_st.mem_addr = 24'(st.addr + 24'h00_0001);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st         <= '0; // RULE5 RULE24
      st.sel_q   <= 1'b1;
      st.phase   <= sfcp_pkg::P_OP;
      st.op_kind <= sfcp_pkg::OP_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign dual_line_high_out = st.do_out;
  assign dual_line_high_oe  = st.do_oe;
  assign dual_line_low_out  = st.di_out;
  assign dual_line_low_oe   = st.di_oe;
  assign op_valid           = st.op_valid;
  assign op_kind            = st.op_kind;
  assign op_addr            = st.op_addr;
  assign mem_addr           = st.mem_addr;
  assign status_byte        = stat_of(st, 1'b0);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_write_enable_cmd_ok;
    exec_ev && st.opcode == sfcp_pkg::OPC_WRITE_ENABLE_CMD_CMD && st.opdone && st.bitcnt == 3'h0 &&
    !core_busy && !st.sleep;
  endsequence

  sequence s_status_write_cmd_ok;
    exec_ev && st.opcode == sfcp_pkg::OPC_WR_STAT && st.opdone && st.bitcnt == 3'h0 &&
    st.bytecnt == 3'h1 && st.write_enable_latch && !core_busy && !st.sleep && (!st.status_lock_select || pin_wp_b);
  endsequence

  a_lock_sticky: assert property (st.lb |=> st.lb) // RULE6
    else $error("security lock bit cleared");

  a_hw_lock: assert property (!$stable({st.status_lock_select, st.cmp, st.bp}) |-> $past(!st.status_lock_select || pin_wp_b)) // RULE2
    else $error("status written while hardware locked");

  a_wel_gate: assert property (st.op_valid && st.op_kind != sfcp_pkg::OP_SLEEP &&
                               st.op_kind != sfcp_pkg::OP_WAKE |-> $past(st.write_enable_latch)) // RULE23
    else $error("modifying command without write enable");

  a_write_enable_cmd_sets: assert property (s_write_enable_cmd_ok |=> st.write_enable_latch ##1 st.write_enable_latch) // RULE12
    else $error("write enable did not set latch");

  a_status_write: assert property (s_status_write_cmd_ok |=> st.op_valid && !st.write_enable_latch &&
                                   st.bp == $past(wr_bp)) // RULE3
    else $error("accepted status write not applied");

  a_frame_reject: assert property (exec_ev && st.bitcnt != 3'h0 &&
                                   st.opcode != sfcp_pkg::OPC_WAKE |=>
                                   !st.op_valid && $stable(st.write_enable_latch) && $stable(st.bp)) // RULE10
    else $error("misaligned command executed");

  a_pp_partial: assert property (exec_ev && st.opcode == sfcp_pkg::OPC_PAGE &&
                                 st.bitcnt != 3'h0 && st.write_enable_latch |=> st.write_enable_latch && st.flush) // RULE11
    else $error("partial page program not discarded");

  a_unknown_quiet: assert property (st.phase == sfcp_pkg::P_IGNORE |-> !st.do_oe && !st.di_oe) // RULE26
    else $error("output driven for ignored opcode");

  a_select_idle: assert property (pin_sel_b [*2] |-> !st.do_oe && !st.di_oe) // RULE9
    else $error("output driven while deselected");

  a_dual_only: assert property (st.di_oe |-> st.opcode == sfcp_pkg::OPC_DUAL) // RULE17
    else $error("low line driven outside dual read");

endmodule : sfcp_top
`default_nettype wire

/* File: sfcp_host.sv */
// Link host model: select, serial clock and data in, mode 0 framing.
// Assumes clk runs at 100 MHz; one link period is 8 clk (80 ns).
`timescale 1ns/10ps
`default_nettype none
module sfcp_host (
  // Clock
  input  wire logic clk,
  // Link
  output var  logic select_b,
  output var  logic serial_clk,
  output var  logic mosi,
  input  wire logic miso
);
  initial begin
    select_b = 1'b1;
    serial_clk = 1'b0;
    mosi = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Select change; released data line shows the inverse of its last value
  task automatic sel(input logic lvl);
    @(posedge clk);
    select_b <= lvl;
    if (lvl) mosi <= ~mosi;
    cyc(8);
  endtask : sel

  // Shifts n bits, MSB first; returns bits seen on the out line
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    for (int i = n - 1; i >= 0; i--) begin
      mosi <= tx[i];
      cyc(4);
      serial_clk <= 1'b1;
      cyc(4);
      rx = {rx[6:0], miso};
      serial_clk <= 1'b0;
    end
  endtask : bits
endmodule : sfcp_host
`default_nettype wire

/* File: tb.sv */
// Bench for the command front end: framing, protection, reads, program buffer.
// Assumes sfcp_pkg, the design files and sfcp_host are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic              clk = 1'b0;
  logic              rst_b, wp_b, core_busy, prog_ready, oe_seen, line0;
  logic              sel_b, sclk, mosi, lo_out, lo_oe, hi_out, hi_oe;
  logic              op_valid, prog_valid;
  logic [7:0]        mem_rdata, prog_data, status_byte, q[$];
  logic [23:0]       op_addr, mem_addr, last_addr;
  logic [15:0]       r;
  sfcp_pkg::sfcp_op_e op_kind, last_kind;
  int                errors = 0, checks_done = 0, ops = 0, o;
  logic [7:0]        eop [5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
  sfcp_pkg::sfcp_op_e ek [5] = '{sfcp_pkg::OP_SECTOR, sfcp_pkg::OP_BLK32,
    sfcp_pkg::OP_BLK64, sfcp_pkg::OP_CHIP, sfcp_pkg::OP_CHIP};

  always #5 clk = ~clk;
  assign line0 = lo_oe ? lo_out : mosi;
  always @(posedge clk) mem_rdata <= mem_addr[7:0] ^ 8'h3c;
  always @(posedge clk) begin
    if (hi_oe !== 1'b0) oe_seen = 1'b1;
    if (op_valid === 1'b1) begin
      ops++;
      last_kind <= op_kind;
      last_addr <= op_addr;
    end
  end

  sfcp_host sfcp_host_inst (.clk(clk), .select_b(sel_b), .serial_clk(sclk), .mosi(mosi),
    .miso(hi_out));
  sfcp_top #(.FIFO_W(8), .FIFO_D(sfcp_pkg::FIFO_DEPTH)) sfcp_top_inst (.clk(clk),
    .rst_b(rst_b), .select_b(sel_b), .serial_clk(sclk), .dual_line_low_in(line0),
    .dual_line_low_out(lo_out), .dual_line_low_oe(lo_oe), .dual_line_high_out(hi_out),
    .dual_line_high_oe(hi_oe), .write_protect_b(wp_b), .core_busy(core_busy),
    .op_valid(op_valid), .op_kind(op_kind), .op_addr(op_addr), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .prog_valid(prog_valid), .prog_ready(prog_ready),
    .prog_data(prog_data), .status_byte(status_byte));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One frame: bytes out, nrd bytes read back, tail partial bits
  task automatic cmd(input logic [7:0] b[$], input int nrd, input int tail,
                     output logic [15:0] rd);
    logic [7:0] x;
    sfcp_host_inst.sel(1'b0);
    foreach (b[i]) sfcp_host_inst.bits(b[i], 8, x);
    for (int i = 0; i < nrd; i++) begin
      sfcp_host_inst.bits(8'h00, 8, x);
      rd = {rd[7:0], x};
    end
    if (tail > 0) sfcp_host_inst.bits(8'h00, tail, x);
    sfcp_host_inst.sel(1'b1);
  endtask : cmd

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    core_busy = 1'b0;
    prog_ready = 1'b0;
    oe_seen = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    check(status_byte, 8'h00);
    cmd('{8'h06}, 0, 0, r);
    check(status_byte[1], 1'b1);
    cmd('{8'h04}, 0, 0, r);
    check(status_byte[1], 1'b0);
    cmd('{8'h06}, 0, 1, r);
    check(status_byte[1], 1'b0);
    o = ops;
    cmd('{8'h20, 8'h00, 8'h00, 8'h00}, 0, 0, r);
    check(ops, o);
    for (int i = 0; i < 5; i++) begin
      o = ops;
      q = '{eop[i]};
      if (i < 3) q = {q, 8'h12, 8'h34, 8'h56};
      cmd('{8'h06}, 0, 0, r);
      cmd(q, 0, 0, r);
      check(ops, o + 1);
      check(last_kind, ek[i]);
      if (i < 3) check(last_addr, 24'h12_3456);
      check(status_byte[1], 1'b0);
    end
    $display("test framing and erase done");
    cmd('{8'h06}, 0, 0, r);
    cmd('{8'h01, 8'hbf}, 0, 0, r);
    check(status_byte, 8'hbc);
    wp_b <= 1'b0;
    cmd('{8'h06}, 0, 0, r);
    cmd('{8'h01, 8'h00}, 0, 0, r);
    check(status_byte, 8'hbe);
    wp_b <= 1'b1;
    cmd('{8'h01, 8'h43}, 0, 0, r);
    check(status_byte, 8'h40);
    wp_b <= 1'b0;
    cmd('{8'h06}, 0, 0, r);
    cmd('{8'h01, 8'h00}, 0, 0, r);
    check(status_byte, 8'h40);
    o = ops;
    cmd('{8'h06}, 0, 0, r);
    cmd('{8'h44, 8'h00, 8'h00, 8'h00}, 0, 0, r);
    check(ops, o);
    cmd('{8'h05}, 2, 0, r);
    check(r, 16'h4242);
    $display("test protection done");
    cmd('{8'h03, 8'h00, 8'h00, 8'h10}, 2, 0, r);
    check(r, 16'h2c2d);
    cmd('{8'h0b, 8'h00, 8'h00, 8'h20, 8'h00}, 2, 0, r);
    check(r, 16'h1c1d);
    cmd('{8'h3b, 8'h00, 8'h00, 8'h30, 8'h00}, 1, 0, r);
    check(r[7:0], 8'h22);
    cmd('{8'h90, 8'h00, 8'h00, 8'h00}, 2, 0, r);
    check(r, {sfcp_pkg::MAKER_CODE, sfcp_pkg::DEVICE_CODE});
    oe_seen = 1'b0;
    cmd('{8'hff}, 1, 0, r);
    check(oe_seen, 1'b0);
    $display("test reads done");
    q = '{8'h02, 8'h00, 8'h01, 8'h00};
    for (int i = 0; i <= sfcp_pkg::FIFO_DEPTH; i++) q.push_back(i[7:0]);
    o = ops;
    cmd(q, 0, 0, r);
    check(ops, o);
    check(prog_valid, 1'b0);
    cmd('{8'h02, 8'h00, 8'h01, 8'h00, 8'ha1}, 0, 3, r);
    check(ops, o);
    check(status_byte[1], 1'b1);
    cmd('{8'h02, 8'h00, 8'h01, 8'h00, 8'ha1, 8'hb2}, 0, 0, r);
    check(last_kind, sfcp_pkg::OP_PAGE);
    check(last_addr, 24'h00_0100);
    for (int i = 0; i < 2; i++) begin
      check(prog_data, i ? 8'hb2 : 8'ha1);
      prog_ready <= 1'b1;
      @(posedge clk);
      prog_ready <= 1'b0;
      @(posedge clk);
    end
    check(prog_valid, 1'b0);
    $display("test program done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
